//--- hpc_pkg.sv
/*
  Shared constants for the host port pin control block.
  Assumes a single 40 MHz device clock and synchronous host pin inputs.
*/
`default_nettype none
package hpc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int CLK_PERIOD_NS = 25;
  // Time a transfer is held busy before ready returns
  localparam int SERVICE_NS = 50;
  localparam int SERVICE_CYC = (SERVICE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] REG_CONTROL = 2'h0;
  localparam logic [1:0] REG_DATA_INC = 2'h1;
  localparam logic [1:0] REG_ADDRESS = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  typedef enum logic [1:0] {
    HPC_TGT_CONTROL,
    HPC_TGT_ADDRESS,
    HPC_TGT_DATA
  } hpc_target_type;
endpackage
`default_nettype wire

//--- hpc_host_port.sv
/*
  Host port pin control: address latch, direction, ready, interrupt, straps.
  Assumes host pins are synchronous to clk_i; tri-state is resolved outside
  from the output enables.
*/
// Overview of operation
// - A pulse on the address latch strobe loads the host address register from the pins.
// - The direction input chooses a read from the port or a write into it for each access.
// - Ready is high when a new transfer may start and low while one is being serviced.
// - Ready floats whenever the output float control input is low.
// - An interrupt output lets the device request host attention.
// - During reset the interrupt output is high, meaning inactive, and is driven only while the output float control input is high.
// - The interrupt output floats whenever the output float control input is low.
// - With the wide mode strap at 1 the interrupt output is not used.
// - The port select strap is caught as reset releases and held until the next reset.
// - With the strap caught low the port is deselected and never drives the data pins.
// - Wide 16-bit mode is on only when its strap is high.
// - In 8-bit mode the two select inputs pick one of three port registers.
`default_nettype none
module hpc_host_port #(
  parameter int SERVICE_CYC = hpc_pkg::SERVICE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic host_port_select_strap_i,
  input wire logic wide_host_mode_strap_i,
  input wire logic output_float_n_i,
  input wire logic port_select_n_i,
  input wire logic addr_strobe_n_i,
  input wire logic data_strobe_n_i,
  input wire logic transfer_direction_i,
  input wire logic reg_select_lo_i,
  input wire logic reg_select_hi_i,
  input wire logic [hpc_pkg::DATA_W-1:0] host_data_i,
  output logic [hpc_pkg::DATA_W-1:0] host_data_o,
  output logic host_data_oe_o,
  output logic host_ready_out_o,
  output logic host_ready_oe_o,
  output logic host_interrupt_out_o,
  output logic host_interrupt_oe_o,
  input wire logic int_request_i,
  input wire logic int_clear_i,
  input wire logic [hpc_pkg::DATA_W-1:0] read_data_i,
  output logic [hpc_pkg::ADDR_W-1:0] host_address_o,
  output logic access_pulse_o,
  output logic access_write_o,
  output hpc_pkg::hpc_target_type access_target_o,
  output logic [hpc_pkg::DATA_W-1:0] write_data_o,
  output logic port_enabled_o,
  output logic wide_mode_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_WAIT_END} hpc_state_type;

  hpc_state_type state_reg, state_next;
  logic in_reset_reg, in_reset_next;
  logic enabled_reg, enabled_next;
  logic wide_reg, wide_next;
  logic as_d_reg, as_d_next;
  logic [hpc_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] cnt_reg, cnt_next;
  logic int_reg, int_next;
  logic acc_reg, acc_next;
  logic wr_reg, wr_next;
  hpc_pkg::hpc_target_type tgt_reg, tgt_next;
  logic [hpc_pkg::DATA_W-1:0] wdata_reg, wdata_next;
  logic [hpc_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  logic drive_reg, drive_next;
  logic selected;
  logic strobe;
  logic [1:0] sel;

  assign selected = enabled_reg && !in_reset_reg && !port_select_n_i;
  assign strobe = selected && !data_strobe_n_i;
  assign sel = {reg_select_hi_i, reg_select_lo_i};

  // Straps: select caught once as reset lifts, wide mode followed every cycle
  always_comb begin
    in_reset_next = 1'b0;
    enabled_next = enabled_reg;
    if (in_reset_reg) begin
      enabled_next = host_port_select_strap_i;
    end
    wide_next = wide_host_mode_strap_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      in_reset_reg <= 1'b1;
      enabled_reg <= 1'b0;
      wide_reg <= 1'b0;
    end else begin
      in_reset_reg <= in_reset_next;
      enabled_reg <= enabled_next;
      wide_reg <= wide_next;
    end
  end

  // Address latch on the falling edge of its strobe
  always_comb begin
    as_d_next = addr_strobe_n_i;
    addr_next = addr_reg;
    if (selected && as_d_reg && !addr_strobe_n_i) begin
      addr_next = host_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      as_d_reg <= 1'b1;
      addr_reg <= hpc_pkg::ADDR_RST;
    end else begin
      as_d_reg <= as_d_next;
      addr_reg <= addr_next;
    end
  end

  // Transfer sequencing; strobes are ignored until the last one is released
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    acc_next = 1'b0;
    wr_next = wr_reg;
    tgt_next = tgt_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    drive_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (strobe) begin
          acc_next = 1'b1;
          wr_next = !transfer_direction_i;
          wdata_next = host_data_i;
          if (wide_reg) begin
            tgt_next = hpc_pkg::HPC_TGT_DATA;
          end else begin
            case (sel)
              hpc_pkg::REG_CONTROL: tgt_next = hpc_pkg::HPC_TGT_CONTROL;
              hpc_pkg::REG_ADDRESS: tgt_next = hpc_pkg::HPC_TGT_ADDRESS;
              default: tgt_next = hpc_pkg::HPC_TGT_DATA;
            endcase
          end
          cnt_next = 8'(SERVICE_CYC);
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        drive_next = !wr_reg;
        if (!wr_reg) begin
          rdata_next = read_data_i;
        end
        if (cnt_reg <= 8'h01) begin
          state_next = ST_WAIT_END;
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      ST_WAIT_END: begin
        drive_next = !wr_reg && strobe;
        if (!strobe) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      acc_reg <= 1'b0;
      wr_reg <= 1'b0;
      tgt_reg <= hpc_pkg::HPC_TGT_CONTROL;
      wdata_reg <= '0;
      rdata_reg <= '0;
      drive_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      acc_reg <= acc_next;
      wr_reg <= wr_next;
      tgt_reg <= tgt_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      drive_reg <= drive_next;
    end
  end

  // Interrupt level; a request in the same cycle as a clear wins
  always_comb begin
    int_next = int_reg;
    if (int_clear_i) begin
      int_next = 1'b0;
    end
    if (int_request_i && enabled_reg && !wide_reg) begin
      int_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
    end
  end

  assign host_ready_out_o = (state_reg == ST_IDLE);
  assign host_ready_oe_o = output_float_n_i && enabled_reg;
  // Active low pin: high in reset or when unused
  assign host_interrupt_out_o = in_reset_reg || wide_reg || !int_reg;
  assign host_interrupt_oe_o = output_float_n_i && (in_reset_reg || !wide_reg);
  assign host_data_o = rdata_reg;
  assign host_data_oe_o = drive_reg && enabled_reg && output_float_n_i;
  assign host_address_o = addr_reg;
  assign access_pulse_o = acc_reg;
  assign access_write_o = wr_reg;
  assign access_target_o = tgt_reg;
  assign write_data_o = wdata_reg;
  assign port_enabled_o = enabled_reg;
  assign wide_mode_o = wide_reg;
endmodule
`default_nettype wire

//--- hpc_host_port_asserts.sv
/* Host port pin checks; expects to be bound onto hpc_host_port. */
`default_nettype none
module hpc_host_port_asserts (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic output_float_n_i,
  input wire logic transfer_direction_i,
  input wire logic access_pulse_o,
  input wire logic host_ready_out_o,
  input wire logic host_ready_oe_o,
  input wire logic host_interrupt_out_o,
  input wire logic wide_mode_o,
  input wire logic host_interrupt_oe_o,
  input wire logic access_write_o,
  input wire logic port_enabled_o,
  input wire logic host_data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rdy_float: assert property (!output_float_n_i |-> !host_ready_oe_o) else $error("oe");
  a_int_float: assert property (!output_float_n_i |-> !host_interrupt_oe_o)
    else $error("int oe");
  a_int_reset: assert property (disable iff (1'h0) !rst_n_i |=> host_interrupt_out_o)
    else $error("int rst");
  a_wide_int: assert property (wide_mode_o |-> host_interrupt_out_o) else $error("int");
  a_busy_rdy: assert property (access_pulse_o |-> !host_ready_out_o [*3])
    else $error("rdy");
  a_dir_write: assert property (access_pulse_o |->
    access_write_o == !$past(transfer_direction_i)) else $error("dir");
  a_strap_hold: assert property ($past(rst_n_i, 2) && $past(rst_n_i) |->
    $stable(port_enabled_o)) else $error("strap");
  a_off_quiet: assert property (!port_enabled_o |-> !access_pulse_o) else $error("off");
  a_off_nodrive: assert property (!port_enabled_o |-> !host_data_oe_o) else $error("drv");
endmodule
bind hpc_host_port hpc_host_port_asserts u_hpc_host_port_asserts (.*);
`default_nettype wire

//--- hpc_host_model.sv
/* Host processor model; expects the bench clock and drives on falling edges. */
`default_nettype none
module hpc_host_model (
  input wire logic clk_i,
  input wire logic ready_i,
  output logic [21:0] pins_o
);
  // Pins: select_n, addr strobe_n, data strobe_n, direction, select hi/lo, data
  initial pins_o = '1;
  task automatic drive(input logic [5:0] c, input logic [15:0] d, input int n,
    output logic late);
    for (int k = 0; k < 20 && !ready_i; k++) @(negedge clk_i);
    late = !ready_i;
    @(negedge clk_i);
    pins_o = {c, d};
    repeat (n) @(negedge clk_i);
    pins_o[20:19] = 2'h3;
    @(negedge clk_i);
    pins_o = {3'h7, c[2:0], ~d};
  endtask
endmodule
`default_nettype wire

//--- hpc_host_port_tb_top.sv
/* Bench of the host port pins; expects hpc_pkg, hpc_host_port and hpc_host_model. */
`default_nettype none
module hpc_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i, rst_n_i, host_port_select_strap_i, wide_host_mode_strap_i, output_float_n_i;
  logic port_select_n_i, addr_strobe_n_i, data_strobe_n_i, transfer_direction_i, reg_select_lo_i;
  logic reg_select_hi_i, host_data_oe_o, host_ready_out_o, host_ready_oe_o, int_request_i;
  logic host_interrupt_out_o, host_interrupt_oe_o, int_clear_i, access_pulse_o, access_write_o;
  logic port_enabled_o, wide_mode_o;
  logic [15:0] host_data_i, host_data_o, read_data_i, host_address_o, write_data_o;
  hpc_pkg::hpc_target_type access_target_o;
  int error_cnt, samples_checked;
  hpc_host_port u_hpc_host_port (.*);
  hpc_host_model u_hpc_host_model (.clk_i, .ready_i(host_ready_out_o), .pins_o({port_select_n_i,
    addr_strobe_n_i, data_strobe_n_i, transfer_direction_i, reg_select_hi_i, reg_select_lo_i,
    host_data_i}));
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("mismatches %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset(input logic strap);
    {rst_n_i, host_port_select_strap_i} = {1'h0, strap};
    repeat (3) @(negedge clk_i);
    chk(16'(host_interrupt_out_o), 16'h0001);
    rst_n_i = 1'h1;
    @(negedge clk_i);
    host_port_select_strap_i = ~strap;
  endtask
  task automatic t_off();
    logic late;
    do_reset(1'h0);
    fork
      u_hpc_host_model.drive(6'h16, 16'h0042, 6, late);
      begin
        repeat (2) @(negedge clk_i);
        chk(16'(access_pulse_o), 16'h0000);
        repeat (2) @(negedge clk_i);
        chk(16'({port_enabled_o, host_data_oe_o, host_ready_out_o}), 16'h0001);
      end
    join
    chk(16'({late, port_enabled_o, host_data_oe_o}), 16'h0000);
  endtask
  task automatic t_access();
    logic [1:0] s;
    logic late;
    do_reset(1'h1);
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      read_data_i = 16'ha5c0 + 16'(i);
      fork
        u_hpc_host_model.drive({3'h2, s[0], s}, 16'h1230 + 16'(i), 6, late);
        begin
          repeat (2) @(negedge clk_i);
          chk(16'({access_pulse_o, host_ready_out_o}), 16'h0002);
          repeat (4) @(negedge clk_i);
          chk(s[0] ? host_data_o : write_data_o, s[0] ? read_data_i : 16'h1230 + 16'(i));
          chk(16'(host_data_oe_o), 16'(s[0]));
        end
      join
      chk(16'(late), 16'h0000);
      chk(16'({host_ready_out_o, access_write_o}), 16'({1'h1, ~s[0]}));
      chk(16'(access_target_o), 16'(s == 2'h0 ? 0 : s == 2'h2 ? 1 : 2));
    end
    u_hpc_host_model.drive(6'h08, 16'hbeef, 1, late);
    chk(host_address_o, 16'hbeef);
    chk(16'(late), 16'h0000);
  endtask
  task automatic t_int();
    logic late;
    int_request_i = 1'h1;
    @(negedge clk_i);
    int_request_i = 1'h0;
    repeat (2) @(negedge clk_i);
    chk(16'(host_interrupt_out_o), 16'h0000);
    output_float_n_i = 1'h0;
    @(negedge clk_i);
    chk(16'({host_ready_oe_o, host_interrupt_oe_o}), 16'h0000);
    {output_float_n_i, wide_host_mode_strap_i} = 2'h3;
    repeat (2) @(negedge clk_i);
    chk(16'({wide_mode_o, host_interrupt_out_o, host_ready_oe_o}), 16'h0007);
    u_hpc_host_model.drive(6'h10, 16'h5a5a, 1, late);
    chk(16'(access_target_o), 16'(hpc_pkg::HPC_TGT_DATA));
    {wide_host_mode_strap_i, int_clear_i} = 2'h1;
    repeat (2) @(negedge clk_i);
    chk(16'({wide_mode_o, host_interrupt_out_o}), 16'h0001);
    {int_request_i, int_clear_i} = 2'h3;
    @(negedge clk_i);
    {int_request_i, int_clear_i} = 2'h0;
    @(negedge clk_i);
    chk(16'({late, host_interrupt_out_o}), 16'h0000);
  endtask
  initial begin
    {int_request_i, int_clear_i, wide_host_mode_strap_i, output_float_n_i} = 4'h1;
    read_data_i = 16'h0000;
    t_off();
    t_access();
    t_int();
    results();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
